// >>> clock_output_config_pkg.sv
package clock_output_config_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OUTPUT_ROUTING_CONTROL_OFFSET       = 8'h07;
  localparam logic [7:0]  SECOND_DIVIDER_NUMERATOR_LOW_OFFSET = 8'h08;
  localparam logic [15:0] OUTPUT_ROUTING_CONTROL_RESET        = 16'h5d1f;
  localparam logic [15:0] SECOND_DIVIDER_NUMERATOR_LOW_RESET  = 16'hc28f;
  // Top bit is never stored and reads as zero
  localparam logic [15:0] OUTPUT_ROUTING_CONTROL_MASK         = 16'h7fff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MULTI_PIN_ROLE_HI           = 14;
  localparam int MULTI_PIN_ROLE_LO           = 13;
  localparam int AUX_DIVISOR_HI              = 12;
  localparam int AUX_DIVISOR_LO              = 11;
  localparam int AUXILIARY_DIVIDER_SOURCE    = 9;
  localparam int PAIR_TWO_ENABLE             = 8;
  localparam int PAIR_TWO_CHANNEL_SOURCE     = 7;
  localparam int PAIR_TWO_FORMAT_HI          = 4;
  localparam int PAIR_TWO_FORMAT_LO          = 2;
  localparam int PAIR_ONE_ENABLE             = 1;
  localparam int GATE_PIN_POLARITY           = 0;
  localparam int NUMERATOR_HIGH_WIDTH        = 8;
  localparam int NUMERATOR_LOW_WIDTH         = 16;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ROLE_PULLED_LOW  = 2'h0;
  localparam logic [1:0] ROLE_TRISTATE    = 2'h1;
  localparam logic [1:0] ROLE_AUX_CLOCK   = 2'h2;
  localparam logic [1:0] ROLE_CLOCK_READY = 2'h3;

  localparam logic [1:0] AUX_DIV_OFF = 2'h0;
  localparam logic [1:0] AUX_DIV_2   = 2'h1;
  localparam logic [1:0] AUX_DIV_4   = 2'h2;
  localparam logic [1:0] AUX_DIV_8   = 2'h3;

  localparam logic [2:0] FMT_FIRST_ONLY  = 3'h4;
  localparam logic [2:0] FMT_SECOND_ONLY = 3'h5;
  localparam logic [2:0] FMT_ANTIPHASE   = 3'h6;
  localparam logic [2:0] FMT_IN_PHASE    = 3'h7;

endpackage

// >>> clock_output_config_regs.sv
`timescale 1ns/1ps
module clock_output_config_regs
  import clock_output_config_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  output logic      [15:0] REG_RDATA_O,
  input  wire logic        FUSE_LOAD_I,
  input  wire logic [15:0] FUSE_CONTROL_I,
  input  wire logic [15:0] FUSE_NUMERATOR_LOW_I,
  input  wire logic [7:0]  NUMERATOR_HIGH_I,
  output logic      [23:0] SECOND_DIVIDER_NUMERATOR_O,
  input  wire logic        FIRST_FRACTIONAL_DIVIDER_I,
  input  wire logic        SECOND_FRACTIONAL_DIVIDER_I,
  input  wire logic        CHANNEL_ZERO_CLK_I,
  input  wire logic        CHANNEL_ONE_CLK_I,
  input  wire logic        PAIR_ONE_CLK_I,
  input  wire logic [2:0]  PAIR_ONE_FORMAT_I,
  input  wire logic        OUTPUT_GATE_PIN_I,
  input  wire logic        CLOCK_READY_I,
  output logic             MULTI_PIN_O,
  output logic             MULTI_PIN_OE_O,
  output logic             FIRST_OUTPUT_O,
  output logic             SECOND_OUTPUT_O,
  output logic             THIRD_OUTPUT_O,
  output logic             FOURTH_OUTPUT_O
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] control_ff;
  logic [15:0] nxt_control;
  logic [15:0] numerator_low_ff;
  logic [15:0] nxt_numerator_low;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [23:0] numerator_ff;
  logic [23:0] nxt_numerator;

  always_comb
  begin
    nxt_control       = control_ff;
    nxt_numerator_low = numerator_low_ff;
    // Fuse image wins over a host write in the same cycle
    if (FUSE_LOAD_I)
    begin
      nxt_control       = FUSE_CONTROL_I & OUTPUT_ROUTING_CONTROL_MASK;
      nxt_numerator_low = FUSE_NUMERATOR_LOW_I;
    end
    else if (REG_WR_I && REG_ADDR_I == OUTPUT_ROUTING_CONTROL_OFFSET)
    begin
      // Bit 15 is never stored; bits 10 and 6:5 are stored as the host writes them
      nxt_control = REG_WDATA_I & OUTPUT_ROUTING_CONTROL_MASK;
    end
    else if (REG_WR_I && REG_ADDR_I == SECOND_DIVIDER_NUMERATOR_LOW_OFFSET)
    begin
      nxt_numerator_low = REG_WDATA_I;
    end
    case (REG_ADDR_I)
      OUTPUT_ROUTING_CONTROL_OFFSET:       nxt_rdata = control_ff;
      SECOND_DIVIDER_NUMERATOR_LOW_OFFSET: nxt_rdata = numerator_low_ff;
      default:                             nxt_rdata = 16'h0000;
    endcase
    nxt_numerator = {NUMERATOR_HIGH_I, numerator_low_ff};
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      control_ff       <= OUTPUT_ROUTING_CONTROL_RESET;
      numerator_low_ff <= SECOND_DIVIDER_NUMERATOR_LOW_RESET;
      rdata_ff         <= 16'h0000;
      numerator_ff     <= 24'h000000;
    end
    else
    begin
      control_ff       <= nxt_control;
      numerator_low_ff <= nxt_numerator_low;
      rdata_ff         <= nxt_rdata;
      numerator_ff     <= nxt_numerator;
    end
  end

  assign REG_RDATA_O                = rdata_ff;
  assign SECOND_DIVIDER_NUMERATOR_O = numerator_ff;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] multi_pin_role;
  logic [1:0] aux_divisor;
  logic       auxiliary_divider_source;
  logic       pair_two_enable;
  logic       pair_two_channel_source;
  logic [2:0] pair_two_format;
  logic       pair_one_enable;
  logic       gate_polarity;
  logic       gate_active;

  assign multi_pin_role           = control_ff[MULTI_PIN_ROLE_HI:MULTI_PIN_ROLE_LO];
  assign aux_divisor              = control_ff[AUX_DIVISOR_HI:AUX_DIVISOR_LO];
  assign auxiliary_divider_source = control_ff[AUXILIARY_DIVIDER_SOURCE];
  assign pair_two_enable          = control_ff[PAIR_TWO_ENABLE];
  assign pair_two_channel_source  = control_ff[PAIR_TWO_CHANNEL_SOURCE];
  assign pair_two_format          = control_ff[PAIR_TWO_FORMAT_HI:PAIR_TWO_FORMAT_LO];
  assign pair_one_enable          = control_ff[PAIR_ONE_ENABLE];
  assign gate_polarity            = control_ff[GATE_PIN_POLARITY];
  // Polarity flips only the pin sense; enable bits stay active high
  assign gate_active              = OUTPUT_GATE_PIN_I ^ gate_polarity;

  // ----------------------------------------------------------------
  // Auxiliary clock divider
  // ----------------------------------------------------------------
  logic       aux_source;
  logic       aux_source_ff;
  logic [2:0] aux_count_ff;
  logic [2:0] nxt_aux_count;
  logic       aux_clock;

  // Divider outputs are sampled as levels, so they must run well below the clock
  assign aux_source = auxiliary_divider_source ? SECOND_FRACTIONAL_DIVIDER_I
                                               : FIRST_FRACTIONAL_DIVIDER_I;

  always_comb
  begin
    nxt_aux_count = aux_count_ff;
    if (aux_divisor == AUX_DIV_OFF)
      nxt_aux_count = 3'h0;
    else if (aux_source && !aux_source_ff)
      nxt_aux_count = aux_count_ff + 3'h1;
    case (aux_divisor)
      AUX_DIV_2: aux_clock = aux_count_ff[0];
      AUX_DIV_4: aux_clock = aux_count_ff[1];
      AUX_DIV_8: aux_clock = aux_count_ff[2];
      default:   aux_clock = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      aux_source_ff <= 1'b0;
      aux_count_ff  <= 3'h0;
    end
    else
    begin
      aux_source_ff <= aux_source;
      aux_count_ff  <= nxt_aux_count;
    end
  end

  // ----------------------------------------------------------------
  // Pin and output drivers
  // ----------------------------------------------------------------
  logic pin_ff;
  logic nxt_pin;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic first_ff;
  logic nxt_first;
  logic second_ff;
  logic nxt_second;
  logic third_ff;
  logic nxt_third;
  logic fourth_ff;
  logic nxt_fourth;
  logic pair_two_source;

  assign pair_two_source = pair_two_channel_source ? CHANNEL_ONE_CLK_I : CHANNEL_ZERO_CLK_I;

  always_comb
  begin
    nxt_pin_oe = 1'b1;
    nxt_pin    = 1'b0;
    case (multi_pin_role)
      ROLE_PULLED_LOW:  nxt_pin = 1'b0;
      ROLE_TRISTATE:    nxt_pin_oe = 1'b0;
      ROLE_AUX_CLOCK:   nxt_pin = aux_clock;
      ROLE_CLOCK_READY: nxt_pin = CLOCK_READY_I;
      default:          nxt_pin = 1'b0;
    endcase
    nxt_first  = 1'b0;
    nxt_second = 1'b0;
    nxt_third  = 1'b0;
    nxt_fourth = 1'b0;
    // Reserved format codes keep both outputs of a pair low
    if (pair_one_enable && gate_active)
    begin
      case (PAIR_ONE_FORMAT_I)
        FMT_FIRST_ONLY:  nxt_first = PAIR_ONE_CLK_I;
        FMT_SECOND_ONLY: nxt_second = PAIR_ONE_CLK_I;
        FMT_ANTIPHASE:
        begin
          nxt_first  = PAIR_ONE_CLK_I;
          nxt_second = !PAIR_ONE_CLK_I;
        end
        FMT_IN_PHASE:
        begin
          nxt_first  = PAIR_ONE_CLK_I;
          nxt_second = PAIR_ONE_CLK_I;
        end
        default: nxt_first = 1'b0;
      endcase
    end
    if (pair_two_enable && gate_active)
    begin
      case (pair_two_format)
        FMT_FIRST_ONLY:  nxt_third = pair_two_source;
        FMT_SECOND_ONLY: nxt_fourth = pair_two_source;
        FMT_ANTIPHASE:
        begin
          nxt_third  = pair_two_source;
          nxt_fourth = !pair_two_source;
        end
        FMT_IN_PHASE:
        begin
          nxt_third  = pair_two_source;
          nxt_fourth = pair_two_source;
        end
        default: nxt_third = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      pin_ff    <= 1'b0;
      pin_oe_ff <= 1'b0;
      first_ff  <= 1'b0;
      second_ff <= 1'b0;
      third_ff  <= 1'b0;
      fourth_ff <= 1'b0;
    end
    else
    begin
      pin_ff    <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
      first_ff  <= nxt_first;
      second_ff <= nxt_second;
      third_ff  <= nxt_third;
      fourth_ff <= nxt_fourth;
    end
  end

  assign MULTI_PIN_O     = pin_ff;
  assign MULTI_PIN_OE_O  = pin_oe_ff;
  assign FIRST_OUTPUT_O  = first_ff;
  assign SECOND_OUTPUT_O = second_ff;
  assign THIRD_OUTPUT_O  = third_ff;
  assign FOURTH_OUTPUT_O = fourth_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_ctrl_write;
    REG_WR_I && !FUSE_LOAD_I && REG_ADDR_I == OUTPUT_ROUTING_CONTROL_OFFSET;
  endsequence

  sequence s_ctrl_read;
    !REG_WR_I && !FUSE_LOAD_I && REG_ADDR_I == OUTPUT_ROUTING_CONTROL_OFFSET;
  endsequence

  a_pin_tristate: assert property (multi_pin_role == ROLE_TRISTATE |=> !MULTI_PIN_OE_O)
    else $error("multi pin driven in high impedance role");
  a_pin_low: assert property (multi_pin_role == ROLE_PULLED_LOW |=> MULTI_PIN_OE_O && !MULTI_PIN_O)
    else $error("multi pin not pulled low");
  a_ready_mirror: assert property (multi_pin_role == ROLE_CLOCK_READY |=> MULTI_PIN_O == $past(CLOCK_READY_I))
    else $error("multi pin does not follow clock ready");
  a_aux_off: assert property (multi_pin_role == ROLE_AUX_CLOCK && aux_divisor == AUX_DIV_OFF
                              |=> MULTI_PIN_OE_O && !MULTI_PIN_O)
    else $error("auxiliary clock active while disabled");
  a_pair_two_off: assert property (!pair_two_enable |=> !THIRD_OUTPUT_O && !FOURTH_OUTPUT_O)
    else $error("pair two toggles while disabled");
  a_gate_blocks: assert property (!gate_active
                                  |=> !FIRST_OUTPUT_O && !SECOND_OUTPUT_O && !THIRD_OUTPUT_O && !FOURTH_OUTPUT_O)
    else $error("output active while gate pin inactive");
  a_pair_antiphase: assert property (pair_two_enable && gate_active && pair_two_format == FMT_ANTIPHASE
                                     |=> FOURTH_OUTPUT_O == !THIRD_OUTPUT_O)
    else $error("pair two not in antiphase");
  a_numerator_join: assert property (1'b1 ##1 1'b1 |-> SECOND_DIVIDER_NUMERATOR_O ==
                                     {$past(NUMERATOR_HIGH_I), $past(numerator_low_ff)})
    else $error("numerator halves not joined");
  a_ctrl_readback: assert property (s_ctrl_write ##1 s_ctrl_read
                                    |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & OUTPUT_ROUTING_CONTROL_MASK))
    else $error("control register readback wrong");
  a_fuse_load: assert property (FUSE_LOAD_I |=> numerator_low_ff == $past(FUSE_NUMERATOR_LOW_I))
    else $error("fuse image not loaded");

endmodule

// >>> host_write_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host stand-in: one write strobe per request
// ------------------------------------------------------------
module host_write_model
(
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] data_i,
  output logic             wr_o,
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o
);
  logic [15:0] clean;
  always_comb
  begin
    clean = data_i;
    if (addr_i == 8'h07)
    begin
      // Reserved bits are forced so that no host-write readback relies on the block masking them
      clean[15]  = 1'b0;
      clean[10]  = 1'b1;
      clean[6:5] = 2'h0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    wr_o    <= req_i;
    addr_o  <= addr_i;
    wdata_o <= clean;
  end
endmodule

// >>> clock_output_config_regs_bench.sv
`timescale 1ns/1ps
module clock_output_config_regs_bench
  import clock_output_config_pkg::*;
;
  logic clk = 0, rst_n = 0, req = 0, f_load = 0, fd0 = 0, fd1 = 0, ch0 = 0, ch1 = 0, p1clk = 0, gate = 0, rdy = 0;
  logic [7:0]  haddr = 8'h07, num_hi = 8'h00;
  logic [15:0] hdata = 16'h0000, f_ctl = 16'h0000, f_num = 16'h0000;
  logic [2:0]  p1fmt = 3'h7;
  logic wr, pin, oe, o1, o2, o3, o4;
  logic [7:0]  waddr;
  logic [15:0] wdata, rdata;
  logic [23:0] num;
  int bad_count = 0, compares = 0, n;
  typedef struct { logic [7:0] a; logic [15:0] d; logic [7:0] ra; logic [15:0] e; } row_t;
  row_t rows [5] = '{'{8'h07, 16'hffff, 8'h07, 16'h7f9f}, '{8'h07, 16'h0000, 8'h07, 16'h0400},
                     '{8'h08, 16'h1234, 8'h08, 16'h1234}, '{8'h08, 16'hffff, 8'h08, 16'hffff},
                     '{8'h09, 16'habcd, 8'h09, 16'h0000}};

  always #12.5 clk = ~clk;

  host_write_model u_host (.clk_i(clk), .req_i(req), .addr_i(haddr), .data_i(hdata),
                           .wr_o(wr), .addr_o(waddr), .wdata_o(wdata));
  clock_output_config_regs u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_ADDR_I(waddr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .FUSE_LOAD_I(f_load), .FUSE_CONTROL_I(f_ctl),
    .FUSE_NUMERATOR_LOW_I(f_num), .NUMERATOR_HIGH_I(num_hi), .SECOND_DIVIDER_NUMERATOR_O(num),
    .FIRST_FRACTIONAL_DIVIDER_I(fd0), .SECOND_FRACTIONAL_DIVIDER_I(fd1), .CHANNEL_ZERO_CLK_I(ch0),
    .CHANNEL_ONE_CLK_I(ch1), .PAIR_ONE_CLK_I(p1clk), .PAIR_ONE_FORMAT_I(p1fmt), .OUTPUT_GATE_PIN_I(gate),
    .CLOCK_READY_I(rdy), .MULTI_PIN_O(pin), .MULTI_PIN_OE_O(oe), .FIRST_OUTPUT_O(o1),
    .SECOND_OUTPUT_O(o2), .THIRD_OUTPUT_O(o3), .FOURTH_OUTPUT_O(o4));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    haddr = a;
    hdata = d;
    req = 1;
    tick();
    req = 0;
    tick(2);
  endtask
  task automatic rd_reg(logic [7:0] a, logic [15:0] e);
    haddr = a;
    tick(3);
    chk("readback", {8'h00, e}, {8'h00, rdata});
  endtask
  function automatic logic [15:0] ctl(logic [1:0] role, logic [1:0] dv, logic src, logic en2, logic cs,
                                      logic [2:0] fmt, logic en1, logic pol);
    return {1'b0, role, dv, 1'b1, src, en2, cs, 2'h0, fmt, en1, pol};
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    tick(8);
    rst_n = 1;
    tick();
    rd_reg(OUTPUT_ROUTING_CONTROL_OFFSET, OUTPUT_ROUTING_CONTROL_RESET);
    rd_reg(SECOND_DIVIDER_NUMERATOR_LOW_OFFSET, 16'hc28f);
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].ra, rows[i].e);
    end
    num_hi = 8'ha5;
    tick(3);
    chk("numerator", 24'ha5ffff, num);
    // Pair two format codes, reserved ones included, with both source levels
    for (int f = 0; f < 8; f++)
    begin
      wr_reg(8'h07, ctl(2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 3'(f), 1'b1, 1'b1));
      for (int s = 0; s < 2; s++)
      begin
        ch0 = 1'(s);
        ch1 = ~ch0;
        tick(2);
        chk("third", {23'h0, (f == 4 || f >= 6) && s == 1}, {23'h0, o3});
        chk("fourth", {23'h0, (f == 5 || f == 7) ? s == 1 : f == 6 && s == 0}, {23'h0, o4});
      end
    end
    wr_reg(8'h07, ctl(2'h2, 2'h3, 1'b0, 1'b1, 1'b1, 3'h7, 1'b1, 1'b1));
    ch0 = 0;
    ch1 = 1;
    tick(2);
    chk("routed", 24'h1, {23'h0, o3});
    // Gate sense and enables; polarity must never flip the enable bits
    p1clk = 1;
    ch0 = 1;
    for (int i = 0; i < 8; i++)
    begin
      gate = i[0];
      wr_reg(8'h07, ctl(2'h2, 2'h3, 1'b0, ~i[2], 1'b0, 3'h7, i[2], i[1]));
      tick(2);
      chk("first", {23'h0, i[2] & (i[0] ^ i[1])}, {23'h0, o1});
      chk("second", {23'h0, i[2] & (i[0] ^ i[1])}, {23'h0, o2});
      chk("third", {23'h0, ~i[2] & (i[0] ^ i[1])}, {23'h0, o3});
    end
    // Pair one format codes come from outside; reserved codes keep both outputs low
    gate = 0;
    wr_reg(8'h07, ctl(2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 3'h7, 1'b1, 1'b1));
    for (int f = 0; f < 8; f++)
      for (int s = 0; s < 2; s++)
      begin
        p1fmt = 3'(f);
        p1clk = 1'(s);
        tick(2);
        chk("first_fmt", {23'h0, (f == 4 || f >= 6) && s == 1}, {23'h0, o1});
        chk("second_fmt", {23'h0, (f == 5 || f == 7) ? s == 1 : f == 6 && s == 0}, {23'h0, o2});
      end
    p1fmt = 3'h7;
    // Multi-purpose pin roles
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(8'h07, ctl(2'(r), 2'h0, 1'b0, 1'b1, 1'b0, 3'h7, 1'b1, 1'b1));
      for (int c = 0; c < 2; c++)
      begin
        rdy = 1'(c);
        tick(2);
        chk("pin_oe", {23'h0, r != 1}, {23'h0, oe});
        if (r != 1)
          chk("pin", {23'h0, r == 3 && c == 1}, {23'h0, pin});
      end
    end
    // Auxiliary clock: eight edges of the second divider, counted at the pin
    for (int d = 1; d < 4; d++)
      for (int s = 0; s < 2; s++)
      begin
        wr_reg(8'h07, ctl(2'h2, 2'h0, 1'(s), 1'b1, 1'b0, 3'h7, 1'b1, 1'b1));
        wr_reg(8'h07, ctl(2'h2, 2'(d), 1'(s), 1'b1, 1'b0, 3'h7, 1'b1, 1'b1));
        n = 0;
        for (int k = 0; k < 40; k++)
        begin
          logic prev;
          prev = pin;
          fd1 = k < 32 ? k[1] : 1'b0;
          tick();
          if (pin === 1'b1 && prev === 1'b0)
            n++;
        end
        chk("aux_edges", s ? 24'(8 >> d) : 24'h0, 24'(n));
      end
    // Fuse load collides with a host write and wins
    f_ctl = 16'hffff;
    f_num = 16'h1357;
    haddr = 8'h08;
    hdata = 16'h2222;
    req = 1;
    tick();
    req = 0;
    f_load = 1;
    tick();
    f_load = 0;
    rd_reg(8'h08, 16'h1357);
    rd_reg(8'h07, 16'h7fff);
    // Reset in mid-run: outputs drop while held, then the reset configuration drives them
    p1clk = 1;
    ch0 = 1;
    gate = 0;
    rst_n = 0;
    tick(2);
    chk("reset_outputs", 24'h000000, {18'h0, pin, oe, o1, o2, o3, o4});
    chk("reset_numerator", 24'h000000, num);
    rst_n = 1;
    tick(2);
    chk("release_outputs", 24'h00001f, {18'h0, pin, oe, o1, o2, o3, o4});
    chk("release_numerator", 24'ha5c28f, num);
    rd_reg(OUTPUT_ROUTING_CONTROL_OFFSET, OUTPUT_ROUTING_CONTROL_RESET);
    rd_reg(SECOND_DIVIDER_NUMERATOR_LOW_OFFSET, SECOND_DIVIDER_NUMERATOR_LOW_RESET);
    print_verdict();
  end
endmodule
